// ==== rtl/memory_map_cfg.svh ====
// Constants of the memory map decoder: region codes, offsets, bit positions, counts.
// Assumes one 32-bit core bus and a peripheral window owned by this block.
// What this block does
// [R1] Low 4 MB internal memory, top 4 MB peripherals, the rest external bus.
// [R2] Every region uses little-endian byte lanes; no big-endian mode.
// [R3] Primary SRAM of 8 KB; after remap it appears at address zero.
// [R4] Internal memories are 32 bits wide and answer any size in one cycle.
// [R5] Extended SRAM of 128 KB decoded at 0x0010_0000.
// [R6] Writes to the extended SRAM are detected while it emulates code memory.
// [R7] Strap must be stable the last 10 cycles before pin reset release; latched.
// [R8] Strap 1 boots from extended SRAM, 0 from external memory on select zero.
// [R9] After reset the boot memory answers at address zero.
// [R10] Writing one to the remap command bit swaps in the primary SRAM low.
// [R11] Software remaps before using external chip selects 1 to 7.
// [R12] Remap stays set until an internal or pin reset.
// [R13] Undefined external-region address raises abort, data or prefetch by type.
// [R14] Internal reads and peripheral accesses never abort.
// [R15] External unit serves 0x0040_0000 to 0xFFC0_0000 with 1 to 128 MB banks.
// [R16] Each bank has wait states, float time, width and byte-write mode.
// [R17] Peripheral accesses are forced to aligned word accesses.
// [R18] Each peripheral owns 16 KB; the interrupt controller owns 4 KB.
// [R19] Control register bits written one trigger commands; zeros do nothing.
// [R20] Enable sets, disable clears the status bit; zero bits leave it.
// [R21] Unused register bits read zero; software writes them zero.
// [R22] Status ANDed with mask, ORed into one interrupt line; mask readable.
// [R23] Watchdog reset keeps the latched boot mode but clears remap.
// [R24] One remap flag, cleared by any reset, steers the low decode.
`ifndef MEMORY_MAP_CFG_SVH
`define MEMORY_MAP_CFG_SVH
`define REGION_INTERNAL 10'h000
`define REGION_PERIPH 10'h3FF
`define LOW_MB 12'h000
`define EXT_SRAM_MB 12'h001
`define PRIMARY_ALT_MB 12'h003
`define PRIMARY_BYTES 8192
`define EXT_SRAM_BYTES 131072
`define BANK_COUNT 8
`define LOCAL_WINDOW 8'h80
`define IRQ_CTRL_PAGE 10'h3FF
`define REG_REMAP_CTRL 14'h0000
`define REG_PROT_ENABLE 14'h0004
`define REG_PROT_DISABLE 14'h0008
`define REG_PROT_STATUS 14'h000C
`define REG_EVENT_STATUS 14'h0010
`define REG_IRQ_ENABLE 14'h0014
`define REG_IRQ_DISABLE 14'h0018
`define REG_IRQ_MASK 14'h001C
`define REG_BOOT_STATUS 14'h0020
`define BIT_REMAP_CMD 0
`define EVT_WRITE_DETECT 0
`define EVT_EXT_ABORT 1
`define EVT_WIDTH 2
`define BOOT_HOLD_CYCLES 4'hA
`endif

// ==== rtl/memory_map_pkg.sv ====
// Types shared by the memory map decoder and its surroundings.
// Assumes the core issues one request at a time.
`default_nettype none
package memory_map_pkg;
	typedef enum logic [1:0] {SIZE_BYTE = 2'h0, SIZE_HALF = 2'h1, SIZE_WORD = 2'h2} size_type;
	typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_EXT_WAIT = 2'h1, ST_PER_WAIT = 2'h2} state_type;
	typedef struct packed {
		logic valid;
		logic write;
		logic fetch;
		size_type size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} core_req_type;
	typedef struct packed {
		logic valid;
		logic abort;
		logic prefetch_abort;
		logic [31:0] rdata;
	} core_rsp_type;
	typedef struct packed {
		logic enable;
		logic [11:0] base_mb;
		logic [2:0] size_log;
		logic [3:0] wait_states;
		logic [2:0] float_time;
		logic bus16;
		logic byte_write;
	} bank_cfg_type;
	typedef struct packed {
		logic valid;
		logic [2:0] cs;
		logic write;
		logic [3:0] be;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0] wait_states;
		logic [2:0] float_time;
		logic bus16;
		logic byte_write;
	} ext_req_type;
	typedef struct packed {
		logic valid;
		logic irq_ctrl;
		logic [7:0] window;
		logic write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} per_req_type;
endpackage
`default_nettype wire

// ==== rtl/memory_map_decoder_remap.sv ====
// Address decoder, internal SRAMs, boot selection and remap for one core bus.
// Assumes rst_n is the pin reset ANDed with the watchdog reset, and a running clock.
`include "memory_map_cfg.svh"
`default_nettype none
module memory_map_decoder_remap #(
	parameter int PRIMARY_BYTES = `PRIMARY_BYTES,
	parameter int EXT_SRAM_BYTES = `EXT_SRAM_BYTES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic external_reset_n_pin,
	input wire logic boot_select_strap,
	input wire memory_map_pkg::core_req_type core_req,
	output logic core_ready,
	output memory_map_pkg::core_rsp_type core_rsp,
	input wire memory_map_pkg::bank_cfg_type [`BANK_COUNT-1:0] bank_cfg,
	output memory_map_pkg::ext_req_type ext_req,
	input wire logic ext_done,
	input wire logic [31:0] ext_rdata,
	output memory_map_pkg::per_req_type per_req,
	input wire logic per_done,
	input wire logic [31:0] per_rdata,
	output logic irq_source,
	output logic boot_select,
	output logic remap_active
);
	import memory_map_pkg::*;

	localparam int PRIM_AW = $clog2(PRIMARY_BYTES / 4);
	localparam int EXT_AW = $clog2(EXT_SRAM_BYTES / 4);

	function automatic logic [3:0] lane_enables(input size_type size, input logic [1:0] off);
		case (size)
			SIZE_BYTE: lane_enables = 4'h1 << off;
			SIZE_HALF: lane_enables = 4'h3 << off;
			default: lane_enables = 4'hF;
		endcase
	endfunction

	function automatic logic [31:0] lanes_out(input logic [31:0] d, input logic [1:0] off);
		lanes_out = d << {off, 3'h0};
	endfunction

	function automatic logic [31:0] lanes_in(input logic [31:0] w, input logic [1:0] off,
			input size_type size);
		logic [31:0] s;
		s = w >> {off, 3'h0};
		case (size)
			SIZE_BYTE: lanes_in = {24'h000000, s[7:0]};
			SIZE_HALF: lanes_in = {16'h0000, s[15:0]};
			default: lanes_in = s;
		endcase
	endfunction

	function automatic logic bank_hit(input bank_cfg_type c, input logic [11:0] mb);
		logic [11:0] mask;
		mask = 12'hFFF << c.size_log;
		bank_hit = c.enable && (((mb ^ c.base_mb) & mask) == 12'h000);
	endfunction

	// Pin reset and strap come from outside: three stages, no reset so a
	// watchdog reset cannot disturb them.
	logic [2:0] pin_sync;
	logic [2:0] strap_sync;
	always_ff @(posedge core_clk) begin
		pin_sync <= {pin_sync[1:0], external_reset_n_pin};
		strap_sync <= {strap_sync[1:0], boot_select_strap};
	end
	logic pin_low;
	logic pin_high;
	assign pin_low = !pin_sync[1] && !pin_sync[2];
	assign pin_high = pin_sync[1] && pin_sync[2];

	// Boot latch sits outside rst_n so that only the pin reset refreshes it.
	logic [3:0] strap_count;
	logic strap_last;
	logic boot_sel;
	logic [3:0] next_strap_count;
	logic next_strap_last;
	logic next_boot_sel;
	always_comb begin
		next_strap_count = strap_count;
		next_strap_last = strap_sync[2];
		next_boot_sel = boot_sel;
		if (pin_low) begin
			if (strap_sync[1] != strap_sync[2] || strap_sync[2] != strap_last) begin
				next_strap_count = 4'h0;
			end else if (strap_count != `BOOT_HOLD_CYCLES) begin
				next_strap_count = strap_count + 4'h1;
			end
			if (next_strap_count == `BOOT_HOLD_CYCLES) begin
				next_boot_sel = strap_sync[2]; // [R7] [R23]
			end
		end else begin
			// Each pin reset counts its own stable span from zero
			next_strap_count = 4'h0;
		end
	end
	always_ff @(posedge core_clk) begin
		strap_count <= next_strap_count;
		strap_last <= next_strap_last;
		boot_sel <= next_boot_sel;
	end

	state_type state;
	logic remap;
	logic protect_en;
	logic [`EVT_WIDTH-1:0] event_status;
	logic [`EVT_WIDTH-1:0] irq_mask;
	logic [31:0] prim_mem [PRIMARY_BYTES/4];
	logic [31:0] ext_mem [EXT_SRAM_BYTES/4];

	// Decode of the request on the bus
	logic take;
	logic [11:0] mb;
	logic in_int;
	logic in_per;
	logic in_ext;
	logic low_hit;
	logic prim_hit;
	logic ext_sram_sel;
	logic boot_cs0;
	logic ext_match;
	logic [2:0] ext_cs;
	logic ext_go;
	logic ext_abort;
	logic per_local;
	logic per_go;
	logic [13:0] reg_off;
	logic [3:0] be;
	logic [31:0] wlanes;
	logic [PRIM_AW-1:0] prim_idx;
	logic [EXT_AW-1:0] ext_idx;

	assign core_ready = pin_high && state == ST_IDLE;
	assign take = core_req.valid && core_ready;
	assign mb = core_req.addr[31:20];
	assign in_int = core_req.addr[31:22] == `REGION_INTERNAL; // [R1]
	assign in_per = core_req.addr[31:22] == `REGION_PERIPH; // [R1]
	assign in_ext = !in_int && !in_per; // [R1] [R15]
	assign low_hit = in_int && mb == `LOW_MB;
	assign prim_hit = (low_hit && remap) || (in_int && mb == `PRIMARY_ALT_MB); // [R3] [R24]
	assign ext_sram_sel = (low_hit && !remap && boot_sel) ||
		(in_int && mb == `EXT_SRAM_MB); // [R5] [R8] [R9]
	assign boot_cs0 = low_hit && !remap && !boot_sel; // [R8] [R9]
	always_comb begin
		ext_match = 1'b0;
		ext_cs = 3'h0;
		for (int i = `BANK_COUNT - 1; i >= 0; i--) begin
			if (bank_hit(bank_cfg[i], mb)) begin
				ext_match = 1'b1; // [R15]
				ext_cs = 3'(i);
			end
		end
	end
	assign ext_go = boot_cs0 || (in_ext && ext_match);
	assign ext_abort = in_ext && !ext_match; // [R13]
	assign per_local = in_per && core_req.addr[21:14] == `LOCAL_WINDOW; // [R18]
	assign per_go = in_per && !per_local;
	assign reg_off = {core_req.addr[13:2], 2'h0}; // [R17]
	assign be = lane_enables(core_req.size, core_req.addr[1:0]); // [R2]
	assign wlanes = lanes_out(core_req.wdata, core_req.addr[1:0]); // [R2]
	assign prim_idx = core_req.addr[PRIM_AW+1:2];
	assign ext_idx = core_req.addr[EXT_AW+1:2];

	// Asynchronous read keeps internal reads to one cycle with a flopped answer.
	always_ff @(posedge core_clk) begin
		for (int b = 0; b < 4; b++) begin
			if (take && core_req.write && prim_hit && be[b]) begin
				prim_mem[prim_idx][8*b +: 8] <= wlanes[8*b +: 8]; // [R4]
			end
			// Protected bank drops the write, and the event records it
			if (take && core_req.write && ext_sram_sel && !protect_en && be[b]) begin
				ext_mem[ext_idx][8*b +: 8] <= wlanes[8*b +: 8]; // [R4]
			end
		end
	end

	logic [31:0] local_word;
	always_comb begin
		case (reg_off)
			`REG_PROT_STATUS: local_word = {31'h0, protect_en};
			`REG_EVENT_STATUS: local_word = {30'h0, event_status};
			`REG_IRQ_MASK: local_word = {30'h0, irq_mask}; // [R22]
			`REG_BOOT_STATUS: local_word = {30'h0, remap, boot_sel};
			default: local_word = 32'h00000000; // [R21]
		endcase
	end

	state_type next_state;
	logic next_remap;
	logic next_protect_en;
	logic [`EVT_WIDTH-1:0] next_event_status;
	logic [`EVT_WIDTH-1:0] next_irq_mask;
	logic [`EVT_WIDTH-1:0] evt_set;
	logic [`EVT_WIDTH-1:0] evt_clr;
	logic next_irq_source;
	core_rsp_type next_core_rsp;
	ext_req_type next_ext_req;
	per_req_type next_per_req;
	logic [31:0] rd_word;
	logic local_wr;

	always_comb begin
		next_state = state;
		next_remap = remap;
		next_protect_en = protect_en;
		next_irq_mask = irq_mask;
		next_core_rsp = '0;
		next_ext_req = ext_req;
		next_per_req = per_req;
		evt_set = '0;
		evt_clr = '0;
		rd_word = 32'h00000000;
		local_wr = take && per_local && core_req.write;
		if (prim_hit) begin
			rd_word = prim_mem[prim_idx];
		end else if (ext_sram_sel) begin
			rd_word = ext_mem[ext_idx];
		end
		case (state)
			ST_IDLE: begin
				if (take && ext_abort) begin
					next_core_rsp.valid = 1'b1;
					next_core_rsp.abort = 1'b1; // [R13]
					next_core_rsp.prefetch_abort = core_req.fetch; // [R13]
					evt_set[`EVT_EXT_ABORT] = 1'b1;
				end else if (take && ext_go) begin
					next_ext_req.valid = 1'b1;
					next_ext_req.cs = boot_cs0 ? 3'h0 : ext_cs; // [R8]
					next_ext_req.write = core_req.write;
					next_ext_req.be = be; // [R15]
					next_ext_req.addr = core_req.addr;
					next_ext_req.wdata = wlanes;
					next_ext_req.wait_states = bank_cfg[next_ext_req.cs].wait_states; // [R16]
					next_ext_req.float_time = bank_cfg[next_ext_req.cs].float_time; // [R16]
					next_ext_req.bus16 = bank_cfg[next_ext_req.cs].bus16; // [R16]
					next_ext_req.byte_write = bank_cfg[next_ext_req.cs].byte_write; // [R16]
					next_state = ST_EXT_WAIT;
				end else if (take && per_go) begin
					next_per_req.valid = 1'b1;
					next_per_req.irq_ctrl = core_req.addr[21:12] == `IRQ_CTRL_PAGE; // [R18]
					next_per_req.window = core_req.addr[21:14]; // [R18]
					next_per_req.write = core_req.write;
					next_per_req.addr = {core_req.addr[31:2], 2'h0}; // [R17]
					next_per_req.wdata = core_req.wdata;
					next_state = ST_PER_WAIT;
				end else if (take) begin
					next_core_rsp.valid = 1'b1; // [R4] [R14]
					if (per_local && !core_req.write) begin
						next_core_rsp.rdata = local_word;
					end else if (!core_req.write) begin
						next_core_rsp.rdata = lanes_in(rd_word, core_req.addr[1:0],
							core_req.size); // [R2]
					end
				end
				if (take && core_req.write && ext_sram_sel && protect_en) begin
					evt_set[`EVT_WRITE_DETECT] = 1'b1; // [R6]
				end
				if (local_wr) begin
					case (reg_off)
						`REG_REMAP_CTRL: begin
							if (core_req.wdata[`BIT_REMAP_CMD]) begin
								next_remap = 1'b1; // [R10] [R19]
							end
							evt_clr = core_req.wdata[`EVT_WIDTH:1]; // [R19]
						end
						`REG_PROT_ENABLE: begin
							if (core_req.wdata[0]) begin
								next_protect_en = 1'b1; // [R20]
							end
						end
						`REG_PROT_DISABLE: begin
							if (core_req.wdata[0]) begin
								next_protect_en = 1'b0; // [R20]
							end
						end
						`REG_IRQ_ENABLE: next_irq_mask = irq_mask | core_req.wdata[1:0]; // [R22]
						`REG_IRQ_DISABLE: next_irq_mask = irq_mask & ~core_req.wdata[1:0]; // [R22]
						default: next_irq_mask = irq_mask;
					endcase
				end
			end
			ST_EXT_WAIT: begin
				if (ext_done) begin
					next_ext_req.valid = 1'b0;
					next_core_rsp.valid = 1'b1;
					if (!ext_req.write) begin
						next_core_rsp.rdata = lanes_in(ext_rdata, ext_req.addr[1:0],
							ext_req.be == 4'hF ? SIZE_WORD :
							(ext_req.be == 4'h3 || ext_req.be == 4'hC) ? SIZE_HALF :
							SIZE_BYTE); // [R2]
					end
					next_state = ST_IDLE;
				end
			end
			ST_PER_WAIT: begin
				if (per_done) begin
					next_per_req.valid = 1'b0;
					next_core_rsp.valid = 1'b1; // [R14]
					next_core_rsp.rdata = per_req.write ? 32'h00000000 : per_rdata;
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
		// A new event outweighs a clear in the same cycle
		next_event_status = (event_status & ~evt_clr) | evt_set;
		next_irq_source = |(event_status & irq_mask); // [R22]
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			remap <= 1'b0; // [R12] [R23] [R24]
			protect_en <= 1'b0;
			event_status <= '0;
			irq_mask <= '0;
			irq_source <= 1'b0;
			core_rsp <= '0;
			ext_req <= '0;
			per_req <= '0;
		end else begin
			state <= next_state;
			remap <= next_remap;
			protect_en <= next_protect_en;
			event_status <= next_event_status;
			irq_mask <= next_irq_mask;
			irq_source <= next_irq_source;
			core_rsp <= next_core_rsp;
			ext_req <= next_ext_req;
			per_req <= next_per_req;
		end
	end
	assign boot_select = boot_sel;
	assign remap_active = remap;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_ext_abort;
		take && ext_abort |=> core_rsp.valid && core_rsp.abort && event_status[`EVT_EXT_ABORT];
	endproperty
	a_ext_abort: assert property (p_ext_abort) else $error("undefined external access no abort"); // [R13]
	property p_no_abort;
		take && (in_int || in_per) |-> ##[1:300] core_rsp.valid && !core_rsp.abort;
	endproperty
	a_no_abort: assert property (p_no_abort) else $error("abort on internal or peripheral"); // [R14]
	property p_one_cycle;
		take && (prim_hit || ext_sram_sel) |=> core_rsp.valid && core_ready;
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("internal access not single cycle"); // [R4]
	property p_word_align;
		per_req.valid |-> per_req.addr[1:0] == 2'h0 && state == ST_PER_WAIT;
	endproperty
	a_word_align: assert property (p_word_align) else $error("peripheral access not word"); // [R17]
	property p_remap_sticky;
		remap |=> remap;
	endproperty
	a_remap_sticky: assert property (p_remap_sticky) else $error("remap dropped"); // [R12]
	property p_remap_cmd;
		local_wr && reg_off == `REG_REMAP_CTRL && core_req.wdata[0] |=> remap && !boot_cs0;
	endproperty
	a_remap_cmd: assert property (p_remap_cmd) else $error("remap command ignored"); // [R10]
	property p_boot_kept;
		!pin_low |=> $stable(boot_sel);
	endproperty
	a_boot_kept: assert property (p_boot_kept) else $error("boot mode changed outside pin reset"); // [R23]
	property p_write_detect;
		take && core_req.write && ext_sram_sel && protect_en |=> event_status[`EVT_WRITE_DETECT];
	endproperty
	a_write_detect: assert property (p_write_detect) else $error("protected write missed"); // [R6]
	property p_irq_line;
		(|(event_status & irq_mask)) |=> irq_source;
	endproperty
	a_irq_line: assert property (p_irq_line) else $error("interrupt not raised"); // [R22]
	property p_prot_set;
		local_wr && reg_off == `REG_PROT_ENABLE && core_req.wdata[0] |=> protect_en;
	endproperty
	a_prot_set: assert property (p_prot_set) else $error("enable register ignored"); // [R20]
	c_remap: cover property ($rose(remap));
	c_abort: cover property (core_rsp.valid && core_rsp.abort && core_rsp.prefetch_abort);
	c_ext_done: cover property (state == ST_EXT_WAIT ##1 state == ST_IDLE);
	c_irq: cover property ($rose(irq_source));
endmodule // memory_map_decoder_remap
`default_nettype wire

// ==== dv/ext_per_responder.sv ====
// Far-side model: external bus unit and peripheral bus answering the decoder.
// Assumes one outstanding request at a time, answered after a settable delay.
`default_nettype none
module ext_per_responder (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [3:0] delay,
	input wire memory_map_pkg::ext_req_type ext_req,
	output logic ext_done,
	output logic [31:0] ext_rdata,
	input wire memory_map_pkg::per_req_type per_req,
	output logic per_done,
	output logic [31:0] per_rdata,
	output memory_map_pkg::ext_req_type seen_ext,
	output memory_map_pkg::per_req_type seen_per
);
	timeunit 1ns;
	timeprecision 1ps;
	import memory_map_pkg::*;
	logic [3:0] cnt;
	logic done;
	logic [31:0] data;
	logic [31:0] addr;
	assign addr = ext_req.valid ? ext_req.addr : per_req.addr;
	// Data lines toggle outside the answer cycle so a stale sample never matches
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 4'h0;
			done <= 1'b0;
			data <= 32'h0;
		end else if (done || !(ext_req.valid || per_req.valid)) begin
			cnt <= 4'h0;
			done <= 1'b0;
			data <= ~data;
		end else begin
			cnt <= cnt + 4'h1;
			done <= (cnt == delay);
			data <= (cnt == delay) ? {addr[15:0], ~addr[15:0]} : ~data;
			seen_ext <= ext_req;
			seen_per <= per_req;
		end
	end
	assign ext_done = done && ext_req.valid;
	assign per_done = done && per_req.valid;
	assign ext_rdata = data;
	assign per_rdata = data;
endmodule // ext_per_responder
`default_nettype wire

// ==== dv/memory_map_decoder_remap_tb.sv ====
// Self-checking bench for the memory map decoder, one task per scenario.
// Assumes the responder model on the external and peripheral buses.
`include "memory_map_cfg.svh"
`default_nettype none
module memory_map_decoder_remap_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import memory_map_pkg::*;
	logic core_clk = 1'b0;
	logic ext_pin;
	logic wd_n;
	logic rst_n;
	logic boot_select_strap;
	core_req_type core_req;
	logic core_ready;
	core_rsp_type core_rsp;
	core_rsp_type rsp;
	bank_cfg_type [`BANK_COUNT-1:0] banks;
	ext_req_type ext_req;
	ext_req_type seen_ext;
	per_req_type per_req;
	per_req_type seen_per;
	logic ext_done;
	logic per_done;
	logic [31:0] ext_rdata;
	logic [31:0] per_rdata;
	logic [3:0] delay;
	logic irq_source;
	logic boot_select;
	logic remap_active;
	int miscompares = 0;
	int comparisons = 0;
	int lat;
	assign rst_n = ext_pin & wd_n;
	always #2 core_clk = ~core_clk;
	memory_map_decoder_remap #(.PRIMARY_BYTES(64), .EXT_SRAM_BYTES(256)) i_dut (
		.core_clk(core_clk), .rst_n(rst_n), .external_reset_n_pin(ext_pin),
		.boot_select_strap(boot_select_strap), .core_req(core_req), .core_ready(core_ready),
		.core_rsp(core_rsp), .bank_cfg(banks), .ext_req(ext_req), .ext_done(ext_done),
		.ext_rdata(ext_rdata), .per_req(per_req), .per_done(per_done),
		.per_rdata(per_rdata), .irq_source(irq_source), .boot_select(boot_select),
		.remap_active(remap_active));
	ext_per_responder i_far (.core_clk(core_clk), .rst_n(rst_n), .delay(delay),
		.ext_req(ext_req), .ext_done(ext_done), .ext_rdata(ext_rdata), .per_req(per_req),
		.per_done(per_done), .per_rdata(per_rdata), .seen_ext(seen_ext), .seen_per(seen_per));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Request held until the edge that takes it, released just after
	task automatic acc(input logic w, input logic f, input size_type s, input logic [31:0] a,
		input logic [31:0] d);
		int n;
		@(posedge core_clk);
		#1;
		core_req = '{1'b1, w, f, s, a, d};
		for (n = 0; n < 40 && core_ready !== 1'b1; n++) begin
			@(posedge core_clk);
			#1;
		end
		@(posedge core_clk);
		#1;
		core_req.valid = 1'b0;
		for (n = 0; n < 40 && core_rsp.valid !== 1'b1; n++) begin
			@(posedge core_clk);
			#1;
		end
		lat = n;
		rsp = core_rsp;
		check("answer", rsp.valid, 1);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input size_type s = SIZE_WORD);
		acc(1'b1, 1'b0, s, a, d);
	endtask
	task automatic rd(input logic [31:0] a, input size_type s = SIZE_WORD);
		acc(1'b0, 1'b0, s, a, 32'h0);
	endtask
	task automatic pin_reset(input logic strap);
		@(posedge core_clk);
		#1;
		boot_select_strap = strap;
		ext_pin = 1'b0;
		repeat (16) @(posedge core_clk);
		#1;
		ext_pin = 1'b1;
		repeat (5) @(posedge core_clk);
		#1;
	endtask
	task automatic t_boot();
		check("boot", boot_select, 1);
		check("remap", remap_active, 0);
		wr(32'h0000_0004, 32'h1234_5678);
		rd(32'h0010_0004);
		check("boot mem", rsp.rdata, 32'h1234_5678);
		check("latency", lat, 0);
		$display("test boot done");
	endtask
	task automatic t_lanes();
		wr(32'h0010_0010, 32'h4433_2211);
		for (int i = 0; i < 4; i++) begin
			rd(32'h0010_0010 + i, SIZE_BYTE);
			check("byte lane", rsp.rdata, 32'h11 * (i + 1));
		end
		rd(32'h0010_0012, SIZE_HALF);
		check("half", rsp.rdata, 32'h4433);
		wr(32'h0010_0011, 32'hAAAA_AAAA, SIZE_BYTE);
		rd(32'h0010_0010);
		check("byte write", rsp.rdata, 32'h4433_AA11);
		$display("test lanes done");
	endtask
	task automatic t_protect();
		wr(32'hFFE0_0004, 32'h1);
		wr(32'h0010_0010, 32'h0);
		rd(32'h0010_0010);
		check("protected", rsp.rdata, 32'h4433_AA11);
		rd(32'hFFE0_0010);
		check("event", rsp.rdata, 32'h1);
		rd(32'hFFE0_000C);
		check("prot status", rsp.rdata, 32'h1);
		wr(32'hFFE0_0014, 32'h1);
		repeat (2) @(posedge core_clk);
		#1;
		check("irq on", irq_source, 1);
		rd(32'hFFE0_001C);
		check("mask", rsp.rdata, 32'h1);
		wr(32'hFFE0_0018, 32'h1);
		repeat (2) @(posedge core_clk);
		#1;
		check("irq off", irq_source, 0);
		wr(32'hFFE0_0008, 32'h1);
		rd(32'hFFE0_000C);
		check("prot cleared", rsp.rdata, 32'h0);
		wr(32'hFFE0_0000, 32'h2);
		rd(32'hFFE0_0010);
		check("event cleared", rsp.rdata, 32'h0);
		check("no remap", remap_active, 0);
		rd(32'hFFE0_0024);
		check("unused", rsp.rdata, 32'h0);
		$display("test protect done");
	endtask
	task automatic t_abort();
		acc(1'b0, 1'b1, SIZE_WORD, 32'h0800_0000, 32'h0);
		check("fetch abort", {rsp.abort, rsp.prefetch_abort}, 2'b11);
		rd(32'h0800_0000);
		check("data abort", {rsp.abort, rsp.prefetch_abort}, 2'b10);
		rd(32'h0020_0000);
		check("internal hole", rsp.abort, 0);
		check("hole data", rsp.rdata, 32'h0);
		rd(32'hFFF0_0000);
		check("periph hole", rsp.abort, 0);
		rd(32'hFFE0_0010);
		check("abort event", rsp.rdata, 32'h2);
		$display("test abort done");
	endtask
	task automatic t_remap();
		wr(32'h0030_0000, 32'hCAFE_F00D);
		wr(32'hFFE0_0000, 32'h1);
		check("remap set", remap_active, 1);
		rd(32'h0000_0000);
		check("primary low", rsp.rdata, 32'hCAFE_F00D);
		wr(32'hFFE0_0000, 32'h0);
		check("remap kept", remap_active, 1);
		boot_select_strap = 1'b0;
		wd_n = 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		wd_n = 1'b1;
		repeat (4) @(posedge core_clk);
		check("wd remap", remap_active, 0);
		check("wd boot", boot_select, 1);
		rd(32'h0000_0004);
		check("boot again", rsp.rdata, 32'h1234_5678);
		wr(32'hFFE0_0000, 32'h1);
		$display("test remap done");
	endtask
	task automatic t_ext();
		delay = 4'h5;
		wr(32'h0100_0002, 32'hBEEF_BEEF, SIZE_HALF);
		check("cs", seen_ext.cs, 1);
		check("be", seen_ext.be, 4'hC);
		check("wdata", seen_ext.wdata[31:16], 16'hBEEF);
		check("bank timing", {seen_ext.wait_states, seen_ext.float_time}, 7'h1A);
		check("bank width", {seen_ext.bus16, seen_ext.byte_write}, 2'b11);
		rd(32'h0100_0008);
		check("ext read", rsp.rdata, 32'h0008_FFF7);
		rd(32'h0110_0000);
		check("past bank", rsp.abort, 1);
		$display("test ext done");
	endtask
	task automatic t_per();
		delay = 4'h0;
		wr(32'hFFFF_F123, 32'h5555_5555, SIZE_BYTE);
		check("per addr", seen_per.addr, 32'hFFFF_F120);
		check("irq window", {seen_per.irq_ctrl, seen_per.window}, 9'h1FF);
		rd(32'hFFC0_4003, SIZE_HALF);
		check("per addr2", seen_per.addr, 32'hFFC0_4000);
		check("window", {seen_per.irq_ctrl, seen_per.window}, 9'h001);
		$display("test periph done");
	endtask
	task automatic t_pinboot();
		pin_reset(1'b0);
		check("boot ext", boot_select, 0);
		rd(32'h0000_0004);
		check("boot cs", seen_ext.cs, 0);
		check("cs0 wait", seen_ext.wait_states, 4'h2);
		$display("test pin boot done");
	endtask
	initial begin
		ext_pin = 1'b0;
		wd_n = 1'b0;
		boot_select_strap = 1'b1;
		core_req = '0;
		banks = '0;
		banks[0] = '{1'b0, 12'h0, 3'h0, 4'h2, 3'h0, 1'b1, 1'b0};
		banks[1] = '{1'b1, 12'h010, 3'h0, 4'h3, 3'h2, 1'b1, 1'b1};
		delay = 4'h0;
		repeat (2) @(posedge core_clk);
		#1;
		wd_n = 1'b1;
		pin_reset(1'b1);
		t_boot();
		t_lanes();
		t_protect();
		t_abort();
		t_remap();
		t_ext();
		t_per();
		t_pinboot();
		close_out();
	end
	initial begin
		#40000;
		miscompares++;
		close_out();
	end
endmodule // memory_map_decoder_remap_tb
`default_nettype wire
